// ===== verilog/slc_params.svh
// slc_params.svh: offsets, field positions, reset values for the lane config block
// assumes inclusion by bare name; definitions only
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
`define SLC_IDX_LANE_CFG      8'h03
`define SLC_ADDR_LANE_CFG     12'h00c
`define SLC_IDX_GLOBAL_CTRL   8'h01
`define SLC_ADDR_GLOBAL_CTRL  12'h004
`define SLC_ADDR_STATUS       12'h010
`define SLC_LANE_CFG_RESET    16'ha444
`define SLC_GLOBAL_CTRL_RESET 16'h0000
`define SLC_GLOBAL_PD_BIT     15
`define SLC_SWING_HI          15
`define SLC_SWING_LO          12
`define SLC_RSVD_BIT          11
`define SLC_TX_EN_BIT         10
`define SLC_TX_RATE_HI        9
`define SLC_TX_RATE_LO        8
`define SLC_GAIN_HI           7
`define SLC_GAIN_LO           6
`define SLC_AZ_HI             5
`define SLC_AZ_LO             4
`define SLC_UNSCR_BIT         3
`define SLC_RX_EN_BIT         2
`define SLC_RX_RATE_HI        1
`define SLC_RX_RATE_LO        0
`endif

// ===== verilog/slc_pkg.sv
// slc_pkg.sv: types shared by the lane config block
// assumes slc_params.svh holds the numbers
package slc_pkg;
    typedef enum logic [1:0] {
        SLC_RATE_FULL    = 2'h0,
        SLC_RATE_HALF    = 2'h1,
        SLC_RATE_QUARTER = 2'h2,
        SLC_RATE_EIGHTH  = 2'h3
    } slc_rate_t;
    typedef enum logic [1:0] {
        SLC_GAIN_FREEZE_FIRST = 2'h0,
        SLC_GAIN_FREEZE_LOCK  = 2'h1,
        SLC_GAIN_FORCE_OFF    = 2'h2,
        SLC_GAIN_FORCE_ON     = 2'h3
    } slc_gain_t;
    typedef enum logic [1:0] {
        SLC_AZ_ON_ENABLE  = 2'h0,
        SLC_AZ_DISABLED   = 2'h1,
        SLC_AZ_FORCE_UPD  = 2'h2,
        SLC_AZ_FORCE_HOLD = 2'h3
    } slc_az_t;
    // analogue-facing controls of one lane
    typedef struct packed {
        logic [3:0] tx_swing_code;
        logic       transmitter_enable;
        slc_rate_t  tx_rate_select;
        slc_gain_t  gain_loop_mode;
        slc_az_t    auto_zero_mode;
        logic       unscrambled_data_enable;
        logic       receiver_enable;
        slc_rate_t  rx_rate_select;
    } slc_lane_ctrl_t;
    // apb request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } slc_apb_req_t;
endpackage : slc_pkg

// ===== verilog/slc_sync.sv
// slc_sync.sv: two-flop level synchroniser
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module slc_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    // meta stage is read only by the second flop
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // resets to 0 (pin seen as down) so lanes never glitch on before the pin is sampled
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_out <= sync_next;
        end
    end
endmodule : slc_sync

// ===== verilog/slc_lane_cfg.sv
// slc_lane_cfg.sv: lane transmit/receive config register with apb slave
// assumes an apb master on clk; channel_power_down_n is an asynchronous pin
`timescale 1ns/100ps
`include "slc_params.svh"
module slc_lane_cfg (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire slc_pkg::slc_apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  channel_power_down_n,
    output slc_pkg::slc_lane_ctrl_t    lane_ctrl,
    output logic                       tx_active,
    output logic                       rx_active
);
    import slc_pkg::*;

    // reset word as a constant so the reserved bit can be dropped by part-select
    localparam logic [15:0] CFG_RST = `SLC_LANE_CFG_RESET;

    logic [15:0]    cfg_reg;
    logic [15:0]    cfg_next;
    logic [15:0]    glob_reg;
    logic [15:0]    glob_next;
    logic [31:0]    prdata_next;
    logic           pslverr_next;
    logic           pready_next;
    logic           pin_up;
    logic           lanes_down;
    logic           setup;
    logic           access;
    slc_lane_ctrl_t ctrl_next;
    logic           tx_next;
    logic           rx_next;

    // decode a byte address to a known register
    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `SLC_ADDR_LANE_CFG) || (a == `SLC_ADDR_GLOBAL_CTRL) ||
                     (a == `SLC_ADDR_STATUS);
    endfunction : addr_known

    // pin crosses into clk before any gating looks at it
    slc_sync u_pd_sync (
        .clk      (clk),
        .reset    (reset),
        .async_in (channel_power_down_n),
        .sync_out (pin_up)
    );

    // no wait state: answer in the access cycle after setup
    assign setup  = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && pready;
    assign lanes_down = !pin_up || glob_reg[`SLC_GLOBAL_PD_BIT];

    // register writes take effect only on the completing access edge
    always_comb begin
        cfg_next     = cfg_reg;
        glob_next    = glob_reg;
        pready_next  = setup;
        pslverr_next = 1'b0;
        prdata_next  = 32'h0000_0000;
        if (setup) begin
            pslverr_next = !addr_known(apb_req.paddr) ||
                           (apb_req.pwrite && apb_req.paddr == `SLC_ADDR_STATUS);
            unique case (apb_req.paddr)
                `SLC_ADDR_LANE_CFG:    prdata_next = {16'h0000, cfg_reg};
                `SLC_ADDR_GLOBAL_CTRL: prdata_next = {16'h0000, glob_reg};
                `SLC_ADDR_STATUS:      prdata_next = {29'h0000_0000, pin_up, rx_active, tx_active};
                default:               prdata_next = 32'h0000_0000;
            endcase
        end
        if (access && apb_req.pwrite) begin
            if (apb_req.paddr == `SLC_ADDR_LANE_CFG) begin
                cfg_next = apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == `SLC_ADDR_GLOBAL_CTRL) begin
                glob_next = apb_req.pwdata[15:0];
            end
        end
        // hold read data through the access cycle
        if (access) begin
            prdata_next = prdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_reg <= `SLC_LANE_CFG_RESET;
            glob_reg <= `SLC_GLOBAL_CTRL_RESET;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            cfg_reg <= cfg_next;
            glob_reg <= glob_next;
            pready  <= pready_next;
            pslverr <= pslverr_next;
            prdata  <= prdata_next;
        end
    end

    // field split; swing code passes unchanged, amplitude rises with code
    always_comb begin
        ctrl_next.tx_swing_code           = cfg_reg[`SLC_SWING_HI:`SLC_SWING_LO];
        ctrl_next.transmitter_enable      = cfg_reg[`SLC_TX_EN_BIT];
        ctrl_next.tx_rate_select          = slc_rate_t'(cfg_reg[`SLC_TX_RATE_HI:`SLC_TX_RATE_LO]);
        ctrl_next.gain_loop_mode          = slc_gain_t'(cfg_reg[`SLC_GAIN_HI:`SLC_GAIN_LO]);
        ctrl_next.auto_zero_mode          = slc_az_t'(cfg_reg[`SLC_AZ_HI:`SLC_AZ_LO]);
        ctrl_next.unscrambled_data_enable = cfg_reg[`SLC_UNSCR_BIT];
        ctrl_next.receiver_enable         = cfg_reg[`SLC_RX_EN_BIT];
        ctrl_next.rx_rate_select          = slc_rate_t'(cfg_reg[`SLC_RX_RATE_HI:`SLC_RX_RATE_LO]);
        tx_next = cfg_reg[`SLC_TX_EN_BIT] && !lanes_down;
        rx_next = cfg_reg[`SLC_RX_EN_BIT] && !lanes_down;
    end

    // outputs registered: one cycle behind the stored bits
    always_ff @(posedge clk) begin
        if (reset) begin
            lane_ctrl <= slc_lane_ctrl_t'({CFG_RST[15:12], CFG_RST[10:0]});
            tx_active <= 1'b0;
            rx_active <= 1'b0;
        end else begin
            lane_ctrl <= ctrl_next;
            tx_active <= tx_next;
            rx_active <= rx_next;
        end
    end
endmodule : slc_lane_cfg

// ===== sim/slc_lane_cfg_sva.sv
// slc_lane_cfg_sva.sv: port checks for slc_lane_cfg
// assumes one clock and a sync reset; bound below
`timescale 1ns/100ps
module slc_lane_cfg_sva (
    input wire logic                    clk,
    input wire logic                    reset,
    input wire slc_pkg::slc_apb_req_t   apb_req,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    channel_power_down_n,
    input wire slc_pkg::slc_lane_ctrl_t lane_ctrl,
    input wire logic                    tx_active,
    input wire logic                    rx_active
);
    import slc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire cfg_a = apb_req.paddr == 12'h00c;
    wire map_a = apb_req.paddr inside {12'h004, 12'h00c, 12'h010};
    // apb phases
    sequence s_set; apb_req.psel && !apb_req.penable; endsequence
    sequence s_acc; apb_req.psel && apb_req.penable && pready; endsequence
    property p_rdy; s_set |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held");
    property p_idle; !apb_req.psel |=> !pready && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_rst; $fell(reset) |-> lane_ctrl == 15'h5444; endproperty
    a_rst: assert property (p_rst) else $error("bad reset fields");
    // write reaches the lane outputs one edge after commit, checked two ticks after the access
    property p_wr;
        logic [15:0] d;
        (s_acc ##0 (apb_req.pwrite && cfg_a), d = apb_req.pwdata[15:0]) |-> ##2 lane_ctrl == {d[15:12], d[10:0]};
    endproperty
    a_wr: assert property (p_wr) else $error("write not on outputs");
    property p_rd;
        s_acc ##0 (!apb_req.pwrite && cfg_a) |-> !pslverr && {prdata[31:16], prdata[15:12], prdata[10:0]} == {16'h0, lane_ctrl};
    endproperty
    a_rd: assert property (p_rd) else $error("readback differs");
    property p_bad; s_acc ##0 !map_a |-> pslverr && prdata == 32'h0; endproperty
    a_bad: assert property (p_bad) else $error("unmapped not refused");
    property p_pd; !channel_power_down_n [*4] |-> !tx_active && !rx_active; endproperty
    a_pd: assert property (p_pd) else $error("active while pin down");
endmodule : slc_lane_cfg_sva
bind slc_lane_cfg slc_lane_cfg_sva u_sva (.clk(clk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_power_down_n(channel_power_down_n), .lane_ctrl(lane_ctrl),
    .tx_active(tx_active), .rx_active(rx_active));

// ===== sim/tb_slc_lane_cfg.sv
// tb_slc_lane_cfg.sv: self-checking bench for slc_lane_cfg
// assumes the params header on the include path
`timescale 1ns/100ps
`include "slc_params.svh"
module tb_slc_lane_cfg;
    import slc_pkg::*;
    logic           clk = 1'b0;
    logic           reset = 1'b1;
    slc_apb_req_t   req = '0;
    logic           pin_n = 1'b1;
    logic [31:0]    prdata;
    logic           pready, pslverr, tx_active, rx_active;
    slc_lane_ctrl_t lane_ctrl;
    int             bad_count = 0;
    int             n_tests = 0;
    logic [15:0]    m_cfg;
    logic           m_gpd;
    logic [31:0]    rd, r;
    logic           er;
    always #10 clk = ~clk;
    slc_lane_cfg uut (.clk(clk), .reset(reset), .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .channel_power_down_n(pin_n), .lane_ctrl(lane_ctrl), .tx_active(tx_active),
        .rx_active(rx_active));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one transfer, then one idle cycle so req is never assigned twice in a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        req <= '0;
        @(posedge clk);
    endtask : apb
    // readback and lane outputs against the model
    task automatic chk_cfg();
        apb(1'b0, `SLC_ADDR_LANE_CFG, 32'h0);
        chk(rd, {16'h0, m_cfg});
        chk({31'h0, er}, 32'h0);
        chk({17'h0, lane_ctrl}, {17'h0, m_cfg[15:12], m_cfg[10:0]});
    endtask : chk_cfg
    initial begin
        void'($urandom(32'h956ba5e9));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        m_cfg = 16'ha444;
        chk_cfg();
        // every swing code and every rate, gain and auto-zero code
        for (int i = 0; i < 16; i++) begin
            r = $urandom;
            m_cfg = {i[3:0], r[1:0], i[1:0], i[1:0], i[1:0], r[3:2], i[1:0]};
            apb(1'b1, `SLC_ADDR_LANE_CFG, {r[31:16], m_cfg});
            chk_cfg();
        end
        // gating by pin, global power-down and the enable bits
        for (int j = 0; j < 8; j++) begin
            r = $urandom;
            pin_n <= j[0];
            m_gpd = j[1];
            apb(1'b1, `SLC_ADDR_GLOBAL_CTRL, {16'h0, m_gpd, 15'h0});
            m_cfg = r[15:0];
            m_cfg[10] = j[2];
            m_cfg[2] = j[2] ^ r[16];
            apb(1'b1, `SLC_ADDR_LANE_CFG, {16'h0, m_cfg});
            repeat (5) @(posedge clk);
            chk({30'h0, tx_active, rx_active}, {30'h0, j[0] & !m_gpd & m_cfg[10], j[0] & !m_gpd & m_cfg[2]});
            apb(1'b0, `SLC_ADDR_STATUS, 32'h0);
            chk(rd, {29'h0, j[0], j[0] & !m_gpd & m_cfg[2], j[0] & !m_gpd & m_cfg[10]});
            apb(1'b0, `SLC_ADDR_GLOBAL_CTRL, 32'h0);
            chk(rd, {16'h0, m_gpd, 15'h0});
        end
        // refused accesses leave the config alone
        apb(1'b1, 12'h020, 32'hffff);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `SLC_ADDR_STATUS, 32'hffff);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        chk_cfg();
        complete_run();
    end
endmodule : tb_slc_lane_cfg
